// file: src/mts_map.vh
// Contract
// [RULE1] Source selects one of nine trigger origins
// [RULE2] Reset holds off; empty selection picks single-shot
// [RULE3] Configure holds off; measure turns hold/pacer into closure
// [RULE4] Held off source yields no trigger
// [RULE5] One trigger per signalled channel closure
// [RULE6] Single-shot fires once then reverts to hold
// [RULE7] Single-shot unusable with measure operation; a single-shot source write is still accepted while measure is active
// [RULE8] Internal pacer triggers throughout the scan; the measure command turns a selected pacer into closure
// [RULE9] System pulses accepted only with system source
// [RULE10] External port pulse triggers a measurement
// [RULE11] Port zero input only while output drive off
// [RULE12] Output drive off after reset
// [RULE13] Level crossing at threshold percent triggers
// [RULE14] General-purpose port input triggers
// [RULE15] Polarity picks rising or falling edge
// [RULE16] Autorange after trigger, then measure
// [RULE17] Mainframe closes first channel on scan start
// [RULE18] Scan start: auto, advance pulse, key, pacer
// [RULE19] Scan start defaults to automatic
// [RULE20] Scan sources leave trigger settings alone
// [RULE21] Programmed delay precedes first measurement
// [RULE22] No advance until buffer fully transferred
// [RULE23] Inputs synchronised, edges become one pulse
// [RULE24] Triggers during a sequence are ignored
`ifndef MTS_MAP_VH
`define MTS_MAP_VH

// Register byte offsets
`define MTS_REG_SOURCE   8'h00
`define MTS_REG_CONFIG   8'h04
`define MTS_REG_COMMAND  8'h08
`define MTS_REG_STATUS   8'h0C
`define MTS_REG_PACER    8'h10
`define MTS_REG_DELAY    8'h14

// Trigger source codes
`define MTS_SRC_HOLD     4'h0
`define MTS_SRC_CLOSURE  4'h1
`define MTS_SRC_SINGLE   4'h2
`define MTS_SRC_PACER    4'h3
`define MTS_SRC_SYSTEM   4'h4
`define MTS_SRC_EXTERNAL_PORT_ZERO     4'h5
`define MTS_SRC_EXTERNAL_PORT_ONE     4'h6
`define MTS_SRC_LEVEL    4'h7
`define MTS_SRC_GPIO     4'h8

// Field positions
`define MTS_SRC_NONE_BIT 8
`define MTS_CFG_RISE     0
`define MTS_CFG_TRIGGER_OUTPUT_DRIVE  1
`define MTS_CFG_AUTORNG  2
`define MTS_CFG_ARTIME   3
`define MTS_CMD_CONFIGURE_OPERATION     0
`define MTS_CMD_MEAS     1
`define MTS_CMD_ABORT    2
`define MTS_ST_REFUSED   5

// Reset values
`define MTS_CFG_RESET    8'h05
`define MTS_PCT_RESET    8'h32
`define MTS_PACER_RESET  16'h0100
`define MTS_DELAY_RESET  16'h0010

`endif

// file: src/mts_edge_detect.v
`timescale 1ns/1ps
// Qualified edge detector, optionally synchronising an off-domain input
module mts_edge_detect #(
  parameter SYNC = 1
) (
  // Clock and reset
  input  wire mclk,
  input  wire rst,
  // Input and polarity
  input  wire din,
  input  wire rise_sel,
  // One-cycle pulse on qualified edge
  output reg  edge_q
);

  reg meta_q;   // First stage, read only by sync_q
  reg sync_q;   // Second stage or direct copy
  reg prev_q;   // Previous level for edge compare
  wire cur;

  // Two flops for a pin, a single register for on-clock logic
  generate
    if (SYNC != 0) begin : g_sync
      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= din;     // [RULE23]
          sync_q <= meta_q;
        end
      end
    end else begin : g_direct
      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= 1'b0;
          sync_q <= din;
        end
      end
    end
  endgenerate

  assign cur = sync_q;

  // Edge compare; polarity chosen by software
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      prev_q <= cur;
      edge_q <= rise_sel ? (cur & ~prev_q) : (~cur & prev_q);   // [RULE15] [RULE23]
    end
  end

endmodule

// file: src/mts_trigger_selector.v
`timescale 1ns/1ps
`include "mts_map.vh"
// Measurement trigger selector with Avalon-MM register slave
module mts_trigger_selector #(
  parameter PCT_W = 8
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             rst,
  // Avalon-MM slave
  input  wire [7:0]       avs_address,
  input  wire             avs_read,
  input  wire             avs_write,
  input  wire [31:0]      avs_writedata,
  output reg  [31:0]      avs_readdata,
  output reg              avs_waitrequest,
  // Events on this clock
  input  wire             chan_closed,
  input  wire             sys_pulse,
  input  wire [PCT_W-1:0] level_pct,
  // Asynchronous trigger pins
  input  wire             external_port_zero_in,
  input  wire             external_port_one_in,
  input  wire             gpio_in,
  // External port zero drive
  output reg              external_port_zero_out,
  output reg              external_port_zero_oe,
  // Measurement engine
  output reg              range_start,
  input  wire             range_done,
  output reg              meas_start,
  input  wire             meas_done,
  input  wire             buf_empty,
  output reg              seq_busy,
  output reg              advance_ok,
  output reg              measure_active
);

  // Sequence states
  localparam ST_IDLE  = 3'h0;
  localparam ST_DELAY = 3'h1;
  localparam ST_RANGE = 3'h2;
  localparam ST_MEAS  = 3'h3;
  localparam ST_DRAIN = 3'h4;

  // Software-visible state
  reg [3:0]        source_q;     // Selected trigger origin
  reg [7:0]        cfg_q;        // Polarity, drive, autorange bits
  reg [PCT_W-1:0]  pct_q;        // Threshold percent of full scale
  reg [15:0]       pacer_q;      // Pacer period in cycles
  reg [15:0]       delay_q;      // Trigger delay in cycles
  reg              refused_q;    // Sticky refused selection flag
  reg              single_q;     // Pending single-shot trigger
  // Sequence state
  reg [2:0]        state_q;
  reg [15:0]       cnt_q;        // Delay counter
  reg [15:0]       pacer_cnt_q;  // Pacer countdown
  reg              pacer_tick_q; // One-cycle pacer pulse
  reg [31:0]       rdata_d;
  // Bus decode
  wire             req;
  wire             wr_go;
  wire             hit;
  wire             rise;
  wire             external_port_zero_edge;
  wire             external_port_one_edge;
  wire             gpio_edge;
  wire             level_edge;
  wire             above;
  reg              trig_raw;
  wire             src_wr;
  wire             cmd_wr;
  wire [3:0]       new_src;
  wire             refuse;

  assign req    = avs_read | avs_write;
  assign wr_go  = avs_write & ~avs_waitrequest;
  assign src_wr = wr_go & (avs_address == `MTS_REG_SOURCE);
  assign cmd_wr = wr_go & (avs_address == `MTS_REG_COMMAND);
  assign rise   = cfg_q[`MTS_CFG_RISE];
  assign above  = (level_pct >= pct_q);
  assign hit    = (avs_address == `MTS_REG_SOURCE) | (avs_address == `MTS_REG_CONFIG) |
                  (avs_address == `MTS_REG_COMMAND) | (avs_address == `MTS_REG_STATUS) |
                  (avs_address == `MTS_REG_PACER) | (avs_address == `MTS_REG_DELAY);

  // A source write without a source means single-shot
  assign new_src = avs_writedata[`MTS_SRC_NONE_BIT] ? `MTS_SRC_SINGLE : avs_writedata[3:0];   // [RULE2]
  // Port zero cannot be chosen while it drives out; codes above eight are refused too
  assign refuse  = ((new_src == `MTS_SRC_EXTERNAL_PORT_ZERO) & cfg_q[`MTS_CFG_TRIGGER_OUTPUT_DRIVE]) |
                   (new_src > `MTS_SRC_GPIO);   // [RULE11]

  // Edge qualifiers for the pins, synchronised first
  mts_edge_detect #(.SYNC(1)) u_external_port_zero (
    .mclk     (mclk),
    .rst      (rst),
    .din      (external_port_zero_in),
    .rise_sel (rise),
    .edge_q   (external_port_zero_edge)
  );
  mts_edge_detect #(.SYNC(1)) u_external_port_one (
    .mclk     (mclk),
    .rst      (rst),
    .din      (external_port_one_in),
    .rise_sel (rise),
    .edge_q   (external_port_one_edge)
  );
  mts_edge_detect #(.SYNC(1)) u_gpio (
    .mclk     (mclk),
    .rst      (rst),
    .din      (gpio_in),
    .rise_sel (rise),
    .edge_q   (gpio_edge)
  );
  // Level compare is on-clock, so no synchroniser
  mts_edge_detect #(.SYNC(0)) u_level (
    .mclk     (mclk),
    .rst      (rst),
    .din      (above),
    .rise_sel (rise),
    .edge_q   (level_edge)   // [RULE13]
  );

  // Source multiplexer
  always @* begin
    case (source_q)
      `MTS_SRC_HOLD:    trig_raw = 1'b0;            // [RULE4]
      `MTS_SRC_CLOSURE: trig_raw = chan_closed;     // [RULE5]
      `MTS_SRC_SINGLE:  trig_raw = single_q;        // [RULE6]
      `MTS_SRC_PACER:   trig_raw = pacer_tick_q;    // [RULE8]
      `MTS_SRC_SYSTEM:  trig_raw = sys_pulse;       // [RULE9]
      `MTS_SRC_EXTERNAL_PORT_ZERO:    trig_raw = external_port_zero_edge & ~cfg_q[`MTS_CFG_TRIGGER_OUTPUT_DRIVE];   // [RULE10] [RULE11]
      `MTS_SRC_EXTERNAL_PORT_ONE:    trig_raw = external_port_one_edge;       // [RULE10]
      `MTS_SRC_LEVEL:   trig_raw = level_edge;      // [RULE13]
      `MTS_SRC_GPIO:    trig_raw = gpio_edge;       // [RULE14]
      default:          trig_raw = 1'b0;
    endcase
  end

  // Bus handshake: one wait cycle, then a single-cycle answer
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      if (req & avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= rdata_d;
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always @* begin
    rdata_d = 32'h00000000;
    if (hit) begin
      case (avs_address)
        `MTS_REG_SOURCE:  rdata_d = {28'h0000000, source_q};
        `MTS_REG_CONFIG:  rdata_d = {16'h0000, pct_q, cfg_q};
        `MTS_REG_STATUS:  rdata_d = {24'h000000, measure_active, advance_ok, refused_q,
                                     seq_busy, source_q};
        `MTS_REG_PACER:   rdata_d = {16'h0000, pacer_q};
        `MTS_REG_DELAY:   rdata_d = {16'h0000, delay_q};
        default:          rdata_d = 32'h00000000;
      endcase
    end
  end

  // Configuration registers and source selection
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      source_q       <= `MTS_SRC_HOLD;     // [RULE2]
      cfg_q          <= `MTS_CFG_RESET;    // [RULE12] [RULE16]
      pct_q          <= `MTS_PCT_RESET;
      pacer_q        <= `MTS_PACER_RESET;
      delay_q        <= `MTS_DELAY_RESET;
      refused_q      <= 1'b0;
      single_q       <= 1'b0;
      measure_active <= 1'b0;
    end else begin
      single_q <= 1'b0;
      // Single-shot fires once, then the selection falls back to hold
      if (source_q == `MTS_SRC_SINGLE) begin
        source_q <= `MTS_SRC_HOLD;   // [RULE6]
      end
      if (src_wr) begin
        if (!refuse) begin
          source_q <= new_src;   // [RULE1]
          single_q <= (new_src == `MTS_SRC_SINGLE);   // [RULE6]
        end
      end
      // Refused flag: a new refusal wins over a clear in the same cycle
      if (src_wr & refuse) begin
        refused_q <= 1'b1;   // [RULE11]
      end else if (wr_go & (avs_address == `MTS_REG_STATUS) & avs_writedata[`MTS_ST_REFUSED]) begin
        refused_q <= 1'b0;
      end
      if (wr_go & (avs_address == `MTS_REG_CONFIG)) begin
        cfg_q <= avs_writedata[7:0];
        pct_q <= avs_writedata[8+PCT_W-1:8];
      end
      if (wr_go & (avs_address == `MTS_REG_PACER)) begin
        pacer_q <= avs_writedata[15:0];
      end
      if (wr_go & (avs_address == `MTS_REG_DELAY)) begin
        delay_q <= avs_writedata[15:0];
      end
      // Configure holds triggering off and ends any measure operation
      if (cmd_wr & avs_writedata[`MTS_CMD_CONFIGURE_OPERATION]) begin
        source_q       <= `MTS_SRC_HOLD;   // [RULE3]
        single_q       <= 1'b0;
        measure_active <= 1'b0;
      end else if (cmd_wr & avs_writedata[`MTS_CMD_MEAS]) begin
        // Hold (also a spent single-shot) and pacer become closure
        measure_active <= 1'b1;   // [RULE17]
        if ((source_q == `MTS_SRC_HOLD) | (source_q == `MTS_SRC_PACER) |
            (source_q == `MTS_SRC_SINGLE)) begin
          source_q <= `MTS_SRC_CLOSURE;   // [RULE3] [RULE7]
          single_q <= 1'b0;               // [RULE7]
        end
      end else if (cmd_wr & avs_writedata[`MTS_CMD_ABORT]) begin
        measure_active <= 1'b0;
      end
    end
  end

  // Internal pacer; free-runs while selected
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pacer_cnt_q  <= 16'h0000;
      pacer_tick_q <= 1'b0;
    end else begin
      pacer_tick_q <= 1'b0;
      if (source_q != `MTS_SRC_PACER) begin
        pacer_cnt_q <= pacer_q;
      end else if (pacer_cnt_q == 16'h0000) begin
        pacer_cnt_q  <= pacer_q;
        pacer_tick_q <= 1'b1;   // [RULE8]
      end else begin
        pacer_cnt_q <= pacer_cnt_q - 16'h0001;
      end
    end
  end

  // Measurement sequence: delay, optional autorange, measure, drain
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      cnt_q       <= 16'h0000;
      range_start <= 1'b0;
      meas_start  <= 1'b0;
      seq_busy    <= 1'b0;
      advance_ok  <= 1'b1;
      external_port_zero_out    <= 1'b0;
      external_port_zero_oe     <= 1'b0;
    end else begin
      range_start <= 1'b0;
      meas_start  <= 1'b0;
      external_port_zero_out    <= 1'b0;
      // Port zero drives only while output drive is on
      external_port_zero_oe     <= cfg_q[`MTS_CFG_TRIGGER_OUTPUT_DRIVE];   // [RULE11] [RULE12]
      case (state_q)
        ST_IDLE: begin
          seq_busy   <= 1'b0;
          advance_ok <= buf_empty;
          if (trig_raw) begin
            state_q    <= ST_DELAY;
            cnt_q      <= delay_q;   // [RULE21]
            seq_busy   <= 1'b1;
            advance_ok <= 1'b0;
            external_port_zero_out   <= cfg_q[`MTS_CFG_TRIGGER_OUTPUT_DRIVE];
          end
        end
        // Later triggers are dropped, not queued
        ST_DELAY: begin
          if (cnt_q == 16'h0000) begin
            if (cfg_q[`MTS_CFG_AUTORNG] & ~cfg_q[`MTS_CFG_ARTIME]) begin
              state_q     <= ST_RANGE;
              range_start <= 1'b1;   // [RULE16]
            end else begin
              state_q    <= ST_MEAS;
              meas_start <= 1'b1;
            end
          end else begin
            cnt_q <= cnt_q - 16'h0001;   // [RULE21] [RULE24]
          end
        end
        ST_RANGE: begin
          if (range_done) begin
            state_q    <= ST_MEAS;
            meas_start <= 1'b1;   // [RULE16]
          end
        end
        ST_MEAS: begin
          if (meas_done) begin
            state_q <= ST_DRAIN;
          end
        end
        // Hold off advance until every reading has left the buffer
        ST_DRAIN: begin
          if (buf_empty) begin
            state_q    <= ST_IDLE;
            seq_busy   <= 1'b0;
            advance_ok <= 1'b1;   // [RULE22]
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      // Abort and configure end the sequence at once
      if (cmd_wr & (avs_writedata[`MTS_CMD_CONFIGURE_OPERATION] | avs_writedata[`MTS_CMD_ABORT])) begin
        state_q  <= ST_IDLE;
        seq_busy <= 1'b0;
      end
    end
  end

endmodule

// file: sim/mts_far_model.sv
`timescale 1ns/1ps
// Measurement engine and reading buffer facing the selector
module mts_far_model (
  // Clock and reset
  input  logic mclk,
  input  logic rst,
  // Requests from the selector
  input  logic range_start,
  input  logic meas_start,
  // High stretches every answer
  input  logic slow,
  // Mainframe side: measure operation and scan start choice
  input  logic       measure_active,
  input  logic [1:0] start_sel,  // 0 automatic, 1 advance pulse, 2 key, 3 pacer pulse
  input  logic       start_evt,  // Pulse of the chosen non-automatic source
  // Answers
  output logic range_done,
  output logic meas_done,
  output logic buf_empty,
  // Mainframe closes the first channel of the list
  output logic first_close
);
  logic act_q;  // Measure operation seen last cycle
  logic arm_q;  // Waiting for the scan start source
  logic go_st;  // Chosen scan start source fires
  // Automatic start needs no pulse; the other three wait for theirs
  assign go_st = (start_sel == 2'h0) | start_evt;
  // Scan start only closes a channel; it never touches trigger settings
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      act_q       <= 1'b0;
      arm_q       <= 1'b0;
      first_close <= 1'b0;
    end else begin
      act_q       <= measure_active;
      first_close <= 1'b0;
      if (measure_active & ~act_q) begin
        arm_q <= 1'b1;
      end else if (arm_q & go_st) begin
        arm_q       <= 1'b0;
        first_close <= 1'b1;
      end
      // Leaving the measure operation drops a pending start
      if (!measure_active) begin
        arm_q <= 1'b0;
      end
    end
  end
  logic [3:0] rng_q; // Cycles left to range answer
  logic [3:0] mea_q; // Cycles left to reading
  logic [3:0] drn_q; // Cycles left until buffer drained
  logic [3:0] lat;   // Answer latency
  assign lat = slow ? 4'h6 : 4'h1;
  // Each step answers lat cycles after its request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rng_q      <= 4'h0;
      mea_q      <= 4'h0;
      drn_q      <= 4'h0;
      range_done <= 1'b0;
      meas_done  <= 1'b0;
      buf_empty  <= 1'b1;
    end else begin
      range_done <= (rng_q == 4'h1);
      meas_done  <= (mea_q == 4'h1);
      rng_q      <= range_start ? lat : rng_q - {3'h0, rng_q != 4'h0};
      mea_q      <= meas_start ? lat : mea_q - {3'h0, mea_q != 4'h0};
      // Reading sits in the buffer until transferred out
      if (mea_q == 4'h1) begin
        buf_empty <= 1'b0;
        drn_q     <= lat + 4'h2;
      end else if (drn_q != 4'h0) begin
        drn_q     <= drn_q - 4'h1;
        buf_empty <= (drn_q == 4'h1);
      end
    end
  end
endmodule

// file: sim/mts_trigger_selector_assertions.sv
`timescale 1ns/1ps
// Port-level checks on the trigger selector
module mts_trigger_selector_assertions (
  input logic mclk,
  input logic rst,
  input logic avs_read,
  input logic avs_write,
  input logic avs_waitrequest,
  input logic range_start,
  input logic range_done,
  input logic meas_start,
  input logic buf_empty,
  input logic seq_busy,
  input logic advance_ok,
  input logic external_port_zero_out,
  input logic external_port_zero_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Any start of the engine; reset delay is 16 cycles
  wire go = range_start | meas_start;
  a_bus_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  a_wait_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_range_pulse: assert property (range_start |=> !range_start && !meas_start)
    else $error("range start not a lone pulse");
  a_meas_pulse: assert property (meas_start |=> !meas_start)
    else $error("measure start not a pulse");
  a_start_busy: assert property (go |-> seq_busy)
    else $error("engine started outside a sequence");
  a_busy_no_adv: assert property (seq_busy |-> !advance_ok)
    else $error("advance allowed during sequence");
  a_adv_drained: assert property ($rose(advance_ok) |-> $past(buf_empty))
    else $error("advance allowed before buffer drained");
  a_trig_delay: assert property ($rose(seq_busy) |=> !go[*8] ##1 !go[*8] ##1 go)
    else $error("trigger delay not honoured");
  a_range_meas: assert property ($rose(range_done) && seq_busy |=> meas_start)
    else $error("no measurement after autorange");
  a_oe_reset: assert property ($past(rst) |-> !external_port_zero_oe)
    else $error("output drive on after reset");
  a_out_oe: assert property (external_port_zero_out |-> external_port_zero_oe)
    else $error("port zero pulsed without drive");
  c_seq: cover property ($rose(seq_busy));
  c_range: cover property (range_start);
  c_out: cover property (external_port_zero_out);
endmodule
bind mts_trigger_selector mts_trigger_selector_assertions u_mts_trigger_selector_assertions (.mclk, .rst,
  .avs_read, .avs_write, .avs_waitrequest, .range_start, .range_done, .meas_start, .buf_empty, .seq_busy,
  .advance_ok, .external_port_zero_out, .external_port_zero_oe);

// file: sim/mts_trigger_selector_tb.sv
`timescale 1ns/1ps
`include "mts_map.vh"
// Self-checking bench for the trigger selector
module mts_trigger_selector_tb;
  logic        mclk, rst, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address, level_pct;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        chan_closed, sys_pulse, external_port_zero_in, external_port_one_in, gpio_in, external_port_zero_out, external_port_zero_oe;
  logic        range_start, range_done, meas_start, meas_done, buf_empty;
  logic        seq_busy, advance_ok, measure_active, slow, start_evt, first_close;
  logic [1:0]  start_sel;
  int          mismatches, comparisons, cycles, n_rng, n_mea, n_out, k, b;
  logic [3:0]  srcs [6] = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h8, 4'h7}; // Source for each event kind
  mts_trigger_selector #(.PCT_W(8)) u_mts_trigger_selector (.mclk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .chan_closed(chan_closed | first_close),
    .sys_pulse, .level_pct,
    .external_port_zero_in, .external_port_one_in, .gpio_in, .external_port_zero_out, .external_port_zero_oe, .range_start, .range_done, .meas_start,
    .meas_done, .buf_empty, .seq_busy, .advance_ok, .measure_active);
  mts_far_model u_mts_far_model (.mclk, .rst, .range_start, .meas_start, .slow, .measure_active, .start_sel,
    .start_evt, .range_done, .meas_done, .buf_empty, .first_close);
  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Count engine starts and port pulses; cut a hang short
  always @(posedge mclk) begin
    n_rng += range_start;
    n_mea += meas_start;
    n_out += external_port_zero_out;
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    if (mismatches == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Hold the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register read", e, q);
  endtask
  // Let a sequence start, then wait until it drains
  task automatic settle;
    int i;
    i = 0;
    repeat (6) @(posedge mclk);
    while (seq_busy !== 1'b0 && i < 300) begin
      @(posedge mclk);
      i++;
    end
  endtask
  // One event of kind k: rising change, then falling change
  task automatic fire(input int k);
    case (k)
      0: chan_closed <= 1'b1; // Multiplexer closes a channel
      1: sys_pulse <= 1'b1;
      2: external_port_zero_in <= 1'b1;
      3: external_port_one_in <= 1'b1;
      4: gpio_in <= 1'b1;
      default: level_pct <= 8'h40;
    endcase
    @(posedge mclk);
    chan_closed <= 1'b0;
    sys_pulse   <= 1'b0;
    settle();
    {external_port_zero_in, external_port_one_in, gpio_in} <= 3'b000;
    level_pct <= 8'h10;
    settle();
  endtask
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, chan_closed, sys_pulse, external_port_zero_in, external_port_one_in, gpio_in, slow, start_evt} = 9'h000;
    start_sel = 2'h0; // Scan start automatic after reset
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    level_pct = 8'h10;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // Reset values and an unmapped place
    rd(`MTS_REG_SOURCE, 32'h0);
    rd(`MTS_REG_CONFIG, 32'h3205);
    rd(`MTS_REG_STATUS, 32'h40);
    rd(`MTS_REG_PACER, 32'h100);
    rd(`MTS_REG_DELAY, 32'h10);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h0);
    chk("external_port_zero_oe", 32'h0, external_port_zero_oe);
    // Held off: no event may start the engine
    for (k = 0; k < 6; k++) fire(k);
    chk("held off", 32'h0, n_rng + n_mea);
    // Each source answers its own event and not the next kind's event
    for (k = 0; k < 6; k++) begin
      wr(`MTS_REG_SOURCE, {28'h0, srcs[k]});
      b = n_mea;
      fire(k);
      chk("one trigger", b + 1, n_mea);
      chk("autorange first", n_mea, n_rng);
      fire((k + 1) % 6);
      chk("foreign event", b + 1, n_mea);
    end
    // Second closure while busy is dropped
    wr(`MTS_REG_SOURCE, 32'h1);
    b = n_mea;
    chan_closed <= 1'b1;
    @(posedge mclk);
    chan_closed <= 1'b0;
    repeat (3) @(posedge mclk);
    fire(0);
    chk("busy drop", b + 1, n_mea);
    // Falling edge polarity on port one
    wr(`MTS_REG_CONFIG, 32'h3204);
    wr(`MTS_REG_SOURCE, 32'h6);
    b = n_mea;
    external_port_one_in <= 1'b1;
    settle();
    chk("rise ignored", b, n_mea);
    external_port_one_in <= 1'b0;
    settle();
    chk("fall taken", b + 1, n_mea);
    wr(`MTS_REG_CONFIG, 32'h3205);
    // Single shot, chosen directly and by an empty selection
    for (k = 0; k < 2; k++) begin
      b = n_mea;
      wr(`MTS_REG_SOURCE, k ? 32'h100 : 32'h2);
      settle();
      chk("single shot", b + 1, n_mea);
      rd(`MTS_REG_SOURCE, 32'h0);
    end
    // Output drive refuses port zero and pulses it
    wr(`MTS_REG_SOURCE, 32'h1);
    wr(`MTS_REG_CONFIG, 32'h3207);
    @(posedge mclk); // Drive enable follows the setting one cycle later
    chk("external_port_zero_oe", 32'h1, external_port_zero_oe);
    wr(`MTS_REG_SOURCE, 32'h5);
    rd(`MTS_REG_STATUS, 32'h61);
    wr(`MTS_REG_STATUS, 32'h20);
    wr(`MTS_REG_SOURCE, 32'h9);
    rd(`MTS_REG_STATUS, 32'h61);
    b = n_out;
    fire(0);
    chk("drive pulse", b + 1, n_out);
    // Reset in mid-run clears the drive
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(`MTS_REG_CONFIG, 32'h3205);
    chk("external_port_zero_oe", 32'h0, external_port_zero_oe);
    // Pacer with a slow engine, then measure and configure
    slow <= 1'b1;
    wr(`MTS_REG_PACER, 32'h40);
    wr(`MTS_REG_SOURCE, 32'h3);
    b = n_mea;
    repeat (300) @(posedge mclk);
    wr(`MTS_REG_COMMAND, 32'h2);
    settle();
    chk("pacer count", 32'h1, (n_mea - b) >= 4);
    rd(`MTS_REG_SOURCE, 32'h1);
    rd(`MTS_REG_STATUS, 32'hC1);
    wr(`MTS_REG_COMMAND, 32'h1);
    rd(`MTS_REG_STATUS, 32'h40);
    // Automatic scan start closes the first channel once
    b = n_mea;
    wr(`MTS_REG_COMMAND, 32'h2);
    settle();
    chk("scan start", b + 1, n_mea);
    rd(`MTS_REG_SOURCE, 32'h1);
    wr(`MTS_REG_COMMAND, 32'h1);
    rd(`MTS_REG_SOURCE, 32'h0);
    // Key as scan start: no closure until the key pulse
    start_sel <= 2'h2;
    b = n_mea;
    wr(`MTS_REG_COMMAND, 32'h2);
    settle();
    chk("scan waits", b, n_mea);
    start_evt <= 1'b1;
    @(posedge mclk);
    start_evt <= 1'b0;
    settle();
    chk("scan key", b + 1, n_mea);
    report_and_stop();
  end
endmodule
